// *** uerr_regs.sv ***
// event routing registers of the uart: publish, shortcuts, interrupt
// assumes event pulses come from logic on ref_clk, one cycle each
`timescale 1ns/1ps
`default_nettype none

module uerr_regs #(
    parameter int NUM_CH = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire uerr_pkg::uerr_bus_s bus,
    output var  logic [31:0]       rdata,
    input  wire uerr_pkg::uerr_evt_s evt,
    output var  logic [NUM_CH-1:0] publish,
    output var  logic              receive_begin_task,
    output var  logic              receive_halt_task,
    output var  logic              irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] evt_vec(input uerr_pkg::uerr_evt_s e);
        logic [31:0] v;
        v = 32'h00000000;
        v[uerr_pkg::EV_CTS]      = e.clear_to_send_asserted_event;
        v[uerr_pkg::EV_CTS_OFF]  = e.clear_to_send_deasserted_event;
        v[uerr_pkg::EV_RXRDY]    = e.receive_byte_ready_event;
        v[uerr_pkg::EV_RXDONE]   = e.receive_buffer_done_event;
        v[uerr_pkg::EV_TXSENT]   = e.transmit_byte_sent_event;
        v[uerr_pkg::EV_TXDONE]   = e.transmit_buffer_done_event;
        v[uerr_pkg::EV_ERROR]    = e.error_event;
        v[uerr_pkg::EV_RX_TMO]   = e.receiver_timeout_event;
        v[uerr_pkg::EV_RXBEGAN]  = e.receive_began_event;
        v[uerr_pkg::EV_TXBEGAN]  = e.transmit_began_event;
        v[uerr_pkg::EV_TXHALTED] = e.transmit_halted_event;
        return v;
    endfunction

    // one-hot channel strobe for an event, empty while publishing is off
    function automatic logic [NUM_CH-1:0] pub_onehot(input logic [31:0] cfg, input logic ev);
        logic [NUM_CH-1:0] one;
        one = {{(NUM_CH-1){1'b0}}, 1'b1};
        if (ev && cfg[uerr_pkg::PUB_EN_BIT]) begin
            return one << cfg[uerr_pkg::CH_LSB +: uerr_pkg::CH_W];
        end
        return {NUM_CH{1'b0}};
    endfunction

    function automatic logic hit(input uerr_pkg::uerr_bus_s b, input logic [11:0] ofs);
        return b.addr == ofs;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [31:0]       rx_began_pub;
    logic [31:0]       tx_began_pub;
    logic [31:0]       tx_halted_pub;
    logic [31:0]       shortcut;
    logic [31:0]       int_enable;
    logic [31:0]       status;
    logic [31:0]       next_rx_began_pub;
    logic [31:0]       next_tx_began_pub;
    logic [31:0]       next_tx_halted_pub;
    logic [31:0]       next_shortcut;
    logic [31:0]       next_int_enable;
    logic [31:0]       next_status;
    logic [31:0]       next_rdata;
    logic [NUM_CH-1:0] next_publish;
    logic              next_begin_task;
    logic              next_halt_task;
    logic              next_irq;
    logic [31:0]       ev;

    always_comb begin
        ev                 = evt_vec(evt);
        next_rx_began_pub  = rx_began_pub;
        next_tx_began_pub  = tx_began_pub;
        next_tx_halted_pub = tx_halted_pub;
        next_shortcut      = shortcut;
        next_int_enable    = int_enable;
        next_status        = status;
        next_rdata         = 32'h00000000;
        if (bus.wr) begin
            if (hit(bus, uerr_pkg::RX_BEGAN_PUB_OFS)) begin
                next_rx_began_pub = bus.wdata & uerr_pkg::PUB_MASK;
            end else if (hit(bus, uerr_pkg::TX_BEGAN_PUB_OFS)) begin
                next_tx_began_pub = bus.wdata & uerr_pkg::PUB_MASK;
            end else if (hit(bus, uerr_pkg::TX_HALTED_PUB_OFS)) begin
                next_tx_halted_pub = bus.wdata & uerr_pkg::PUB_MASK;
            end else if (hit(bus, uerr_pkg::SHORTCUT_OFS)) begin
                next_shortcut = bus.wdata & uerr_pkg::SC_MASK;
            end else if (hit(bus, uerr_pkg::INT_ENABLE_OFS)) begin
                next_int_enable = bus.wdata & uerr_pkg::INT_MASK;
            end
        end
        if (bus.rd) begin
            if (hit(bus, uerr_pkg::RX_BEGAN_PUB_OFS)) begin
                next_rdata = rx_began_pub;
            end else if (hit(bus, uerr_pkg::TX_BEGAN_PUB_OFS)) begin
                next_rdata = tx_began_pub;
            end else if (hit(bus, uerr_pkg::TX_HALTED_PUB_OFS)) begin
                next_rdata = tx_halted_pub;
            end else if (hit(bus, uerr_pkg::SHORTCUT_OFS)) begin
                next_rdata = shortcut;
            end else if (hit(bus, uerr_pkg::INT_ENABLE_OFS)) begin
                next_rdata = int_enable;
            end else if (hit(bus, uerr_pkg::EVENT_STATUS_OFS)) begin
                next_rdata  = status;
                next_status = 32'h00000000;
            end
        end
        // a new event wins over the read that clears its flag
        next_status = next_status | ev;
        next_publish = pub_onehot(rx_began_pub, evt.receive_began_event)
                     | pub_onehot(tx_began_pub, evt.transmit_began_event)
                     | pub_onehot(tx_halted_pub, evt.transmit_halted_event);
        next_begin_task = evt.receive_buffer_done_event && shortcut[uerr_pkg::SC_START_BIT];
        next_halt_task  = evt.receive_buffer_done_event && shortcut[uerr_pkg::SC_STOP_BIT];
        next_irq        = |(next_status & next_int_enable);
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rx_began_pub       <= uerr_pkg::REG_RESET;
            tx_began_pub       <= uerr_pkg::REG_RESET;
            tx_halted_pub      <= uerr_pkg::REG_RESET;
            shortcut           <= uerr_pkg::REG_RESET;
            int_enable         <= uerr_pkg::REG_RESET;
            status             <= uerr_pkg::REG_RESET;
            rdata              <= 32'h00000000;
            publish            <= {NUM_CH{1'b0}};
            receive_begin_task <= 1'b0;
            receive_halt_task  <= 1'b0;
            irq                <= 1'b0;
        end else begin
            rx_began_pub       <= next_rx_began_pub;
            tx_began_pub       <= next_tx_began_pub;
            tx_halted_pub      <= next_tx_halted_pub;
            shortcut           <= next_shortcut;
            int_enable         <= next_int_enable;
            status             <= next_status;
            rdata              <= next_rdata;
            publish            <= next_publish;
            receive_begin_task <= next_begin_task;
            receive_halt_task  <= next_halt_task;
            irq                <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic [NUM_CH-1:0] one_ch;
    assign one_ch = {{(NUM_CH-1){1'b0}}, 1'b1};

    a_rx_pub_chan: assert property (
        evt.receive_began_event && rx_began_pub[uerr_pkg::PUB_EN_BIT]
        |=> (publish & (one_ch << $past(rx_began_pub[3:0]))) != 0)
        else $error("receive began not published on its channel");

    a_rx_pub_off: assert property (
        !rx_began_pub[uerr_pkg::PUB_EN_BIT] && !evt.transmit_began_event
        && !evt.transmit_halted_event |=> publish == 0)
        else $error("publish seen while disabled");

    a_tx_pub_chan: assert property (
        evt.transmit_began_event && tx_began_pub[uerr_pkg::PUB_EN_BIT]
        |=> (publish & (one_ch << $past(tx_began_pub[3:0]))) != 0)
        else $error("transmit began not published on its channel");

    a_halt_pub_chan: assert property (
        evt.transmit_halted_event && tx_halted_pub[uerr_pkg::PUB_EN_BIT]
        |=> (publish & (one_ch << $past(tx_halted_pub[3:0]))) != 0)
        else $error("transmit halted not published on its channel");

    a_short_start: assert property (
        ##1 receive_begin_task == ($past(evt.receive_buffer_done_event)
        && $past(shortcut[uerr_pkg::SC_START_BIT])))
        else $error("begin task does not follow shortcut");

    a_short_stop: assert property (
        evt.receive_buffer_done_event && !shortcut[uerr_pkg::SC_STOP_BIT]
        |=> !receive_halt_task)
        else $error("halt task fired with shortcut off");

    a_interrupt_enable_mask_write: assert property (
        bus.wr && hit(bus, uerr_pkg::INT_ENABLE_OFS)
        |=> int_enable == ($past(bus.wdata) & uerr_pkg::INT_MASK))
        else $error("interrupt enable not written");

    a_mask_gates: assert property (
        ##1 (irq && int_enable == 0) |-> 0)
        else $error("interrupt with no enable set");

    a_irq_level: assert property (
        irq == ((status & int_enable) != 0))
        else $error("interrupt line disagrees with flags");

    a_status_sticky: assert property (
        evt.transmit_byte_sent_event |=> status[uerr_pkg::EV_TXSENT] ##1
        ($past(bus.rd) || status[uerr_pkg::EV_TXSENT]))
        else $error("flag lost before read");

    a_read_clear: assert property (
        bus.rd && hit(bus, uerr_pkg::EVENT_STATUS_OFS)
        |=> rdata == $past(status) && status == $past(ev))
        else $error("status read did not clear");

    a_reset_zero: assert property (
        @(posedge ref_clk) disable iff (1'b0)
        !resetn |=> int_enable == 0 && shortcut == 0
        && rx_began_pub == 0 && tx_began_pub == 0 && tx_halted_pub == 0)
        else $error("register not zero after reset");

    // ----------------------------------------------------------------
    // write and gating checks
    // ----------------------------------------------------------------
    // an enable write in the same cycle may take the request away
    logic int_en_wr;
    assign int_en_wr = bus.wr && hit(bus, uerr_pkg::INT_ENABLE_OFS);

    a_pub_write: assert property (
        bus.wr && hit(bus, uerr_pkg::RX_BEGAN_PUB_OFS)
        |=> rx_began_pub == ($past(bus.wdata) & uerr_pkg::PUB_MASK))
        else $error("receive began publish config not written");

    a_tx_pub_write: assert property (
        bus.wr && hit(bus, uerr_pkg::TX_BEGAN_PUB_OFS)
        |=> tx_began_pub == ($past(bus.wdata) & uerr_pkg::PUB_MASK))
        else $error("transmit began publish config not written");

    a_halt_pub_write: assert property (
        bus.wr && hit(bus, uerr_pkg::TX_HALTED_PUB_OFS)
        |=> tx_halted_pub == ($past(bus.wdata) & uerr_pkg::PUB_MASK))
        else $error("transmit halted publish config not written");

    a_tx_pub_off: assert property (
        evt.transmit_began_event && !tx_began_pub[uerr_pkg::PUB_EN_BIT]
        && !evt.receive_began_event && !evt.transmit_halted_event
        |=> publish == 0)
        else $error("transmit began published while disabled");

    a_halt_pub_off: assert property (
        evt.transmit_halted_event && !tx_halted_pub[uerr_pkg::PUB_EN_BIT]
        && !evt.receive_began_event && !evt.transmit_began_event
        |=> publish == 0)
        else $error("transmit halted published while disabled");

    a_short_mask: assert property (
        bus.wr && hit(bus, uerr_pkg::SHORTCUT_OFS)
        |=> shortcut == ($past(bus.wdata) & uerr_pkg::SC_MASK))
        else $error("shortcut register not written");

    a_stop_on: assert property (
        evt.receive_buffer_done_event && shortcut[uerr_pkg::SC_STOP_BIT]
        |=> receive_halt_task)
        else $error("halt task missing with shortcut on");

    a_cts_irq: assert property (
        !int_en_wr && (evt.clear_to_send_asserted_event && int_enable[uerr_pkg::EV_CTS]
        || evt.clear_to_send_deasserted_event && int_enable[uerr_pkg::EV_CTS_OFF])
        |=> irq)
        else $error("enabled clear-to-send event raised no interrupt");

    a_rx_irq: assert property (
        !int_en_wr && (evt.receive_byte_ready_event && int_enable[uerr_pkg::EV_RXRDY]
        || evt.receive_buffer_done_event && int_enable[uerr_pkg::EV_RXDONE])
        |=> irq)
        else $error("enabled receive event raised no interrupt");

    a_tx_irq: assert property (
        !int_en_wr && (evt.transmit_byte_sent_event && int_enable[uerr_pkg::EV_TXSENT]
        || evt.transmit_buffer_done_event && int_enable[uerr_pkg::EV_TXDONE])
        |=> irq)
        else $error("enabled transmit event raised no interrupt");

    a_err_irq: assert property (
        !int_en_wr && (evt.error_event && int_enable[uerr_pkg::EV_ERROR]
        || evt.receiver_timeout_event && int_enable[uerr_pkg::EV_RX_TMO])
        |=> irq)
        else $error("enabled error or timeout event raised no interrupt");

    a_began_irq: assert property (
        !int_en_wr && (evt.receive_began_event && int_enable[uerr_pkg::EV_RXBEGAN]
        || evt.transmit_began_event && int_enable[uerr_pkg::EV_TXBEGAN]
        || evt.transmit_halted_event && int_enable[uerr_pkg::EV_TXHALTED])
        |=> irq)
        else $error("enabled began or halted event raised no interrupt");

    a_status_set: assert property (
        ev != 0 |=> (status & $past(ev)) == $past(ev))
        else $error("event flag not set");

    c_publish: cover property (evt.receive_began_event ##1 publish != 0);
    c_shortcut: cover property (receive_begin_task && receive_halt_task);
    c_irq: cover property (!irq ##1 irq);
    c_set_on_clear: cover property (bus.rd && hit(bus, uerr_pkg::EVENT_STATUS_OFS) && ev != 0);
    c_pub_off: cover property (evt.transmit_halted_event && !tx_halted_pub[uerr_pkg::PUB_EN_BIT]);

endmodule

`default_nettype wire

// *** uerr_pkg.sv ***
// constants and carriers of the uart event routing registers
// assumes a single 50 MHz clock and a plain register port
// How it works
// - receive-began publish holds sixteen-way channel index
// - receive-began publish enable gates its publication
// - transmit-began publish: channel index plus enable
// - transmit-halted publish: channel index plus enable
// - end-to-start shortcut fires receive begin task
// - end-to-stop shortcut fires receive halt task
// - separate clear-to-send interrupt enables
// - separate byte-ready and buffer-done receive enables
// - separate byte-sent and buffer-done transmit enables
// - separate error and timeout interrupt enables
package uerr_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] RX_BEGAN_PUB_OFS  = 12'h1CC;
    localparam logic [11:0] TX_BEGAN_PUB_OFS  = 12'h1D0;
    localparam logic [11:0] TX_HALTED_PUB_OFS = 12'h1D8;
    localparam logic [11:0] SHORTCUT_OFS      = 12'h200;
    localparam logic [11:0] INT_ENABLE_OFS    = 12'h300;
    localparam logic [11:0] EVENT_STATUS_OFS  = 12'h380;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int CH_LSB       = 0;
    localparam int CH_W         = 4;
    localparam int PUB_EN_BIT   = 31;
    localparam int SC_START_BIT = 5;
    localparam int SC_STOP_BIT  = 6;
    localparam int EV_CTS       = 0;
    localparam int EV_CTS_OFF   = 1;
    localparam int EV_RXRDY     = 2;
    localparam int EV_RXDONE    = 4;
    localparam int EV_TXSENT    = 7;
    localparam int EV_TXDONE    = 8;
    localparam int EV_ERROR     = 9;
    localparam int EV_RX_TMO    = 17;
    localparam int EV_RXBEGAN   = 19;
    localparam int EV_TXBEGAN   = 20;
    localparam int EV_TXHALTED  = 22;

    localparam logic [31:0] PUB_MASK   = 32'h8000000F;
    localparam logic [31:0] SC_MASK    = 32'h00000060;
    localparam logic [31:0] INT_MASK   = 32'h005A0397;
    localparam logic [31:0] REG_RESET  = 32'h00000000;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } uerr_bus_s;

    typedef struct packed {
        logic clear_to_send_asserted_event;
        logic clear_to_send_deasserted_event;
        logic receive_byte_ready_event;
        logic receive_buffer_done_event;
        logic transmit_byte_sent_event;
        logic transmit_buffer_done_event;
        logic error_event;
        logic receiver_timeout_event;
        logic receive_began_event;
        logic transmit_began_event;
        logic transmit_halted_event;
    } uerr_evt_s;

endpackage

// *** tb.sv ***
// self-checking bench of the uart event routing registers
// assumes uerr_pkg is compiled first and the registers run on ref_clk alone
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                ref_clk = 1'b0;
    logic                resetn  = 1'b0;
    uerr_pkg::uerr_bus_s bus     = '0;
    uerr_pkg::uerr_evt_s ev      = '0;
    logic [31:0]         rdata;
    logic [15:0]         publish;
    logic                receive_begin_task;
    logic                receive_halt_task;
    logic                irq;
    int                  n_fail  = 0;
    int                  n_tests = 0;
    integer              seed    = 32'h7799;
    logic [11:0]         ofs [5] = '{12'h1CC, 12'h1D0, 12'h1D8, 12'h200, 12'h300};
    int                  ibit [11] = '{0, 1, 2, 4, 7, 8, 9, 17, 19, 20, 22};

    uerr_regs #(.NUM_CH(16)) DUT (
        .ref_clk            (ref_clk),
        .resetn             (resetn),
        .bus                (bus),
        .rdata              (rdata),
        .evt                (ev),
        .publish            (publish),
        .receive_begin_task (receive_begin_task),
        .receive_halt_task  (receive_halt_task),
        .irq                (irq)
    );

    always #10 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] wmask(input int k);
        return (k < 3) ? uerr_pkg::PUB_MASK : (k == 3) ? uerr_pkg::SC_MASK : uerr_pkg::INT_MASK;
    endfunction

    function automatic logic [10:0] ev_of(input int i);
        return 11'h400 >> i;
    endfunction

    task automatic wrap_up();
        $display("tests %0d errors %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge ref_clk);
        bus.wr    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge ref_clk);
        bus.rd   <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // one event pulse, then outputs of the following cycle and the one after
    task automatic evp(input logic [10:0] e, input logic [15:0] pub, input logic [1:0] tk, input logic iq);
        @(posedge ref_clk);
        ev <= e;
        @(posedge ref_clk);
        ev <= '0;
        #1;
        chk({16'h0, publish}, {16'h0, pub});
        chk({30'h0, receive_halt_task, receive_begin_task}, {30'h0, tk});
        chk({31'h0, irq}, {31'h0, iq});
        @(posedge ref_clk);
        #1 chk({16'h0, publish} | {30'h0, receive_halt_task, receive_begin_task}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [3:0]  ch;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            rd(ofs[k], 32'h0);
        end
        rd(12'h380, 32'h0);
        rd(12'h1D4, 32'h0);
        for (int k = 0; k < 5; k++) begin
            for (int n = 0; n < 4; n++) begin
                d = (n == 0) ? 32'hFFFFFFFF : $random(seed);
                wr(ofs[k], d);
                rd(ofs[k], d & wmask(k));
            end
            wr(ofs[k], 32'h0);
        end
        for (int i = 8; i < 11; i++) begin
            ch = 4'($random(seed));
            wr(ofs[i - 8], 32'h80000000 | ch);
            evp(ev_of(i), 16'h1 << ch, 2'b00, 1'b0);
            wr(ofs[i - 8], {28'h0, ch});
            evp(ev_of(i), 16'h0, 2'b00, 1'b0);
        end
        for (int s = 0; s < 4; s++) begin
            wr(12'h200, s << uerr_pkg::SC_START_BIT);
            evp(ev_of(3), 16'h0, s[1:0], 1'b0);
        end
        wr(12'h200, 32'h0);
        rd(12'h380, (32'h1 << ibit[3]) | (32'h1 << ibit[8]) | (32'h1 << ibit[9]) | (32'h1 << ibit[10]));
        wr(12'h380, 32'hFFFFFFFF);
        rd(12'h380, 32'h0);
        for (int i = 0; i < 11; i++) begin
            wr(12'h300, uerr_pkg::INT_MASK & ~(32'h1 << ibit[i]));
            evp(ev_of(i), 16'h0, 2'b00, 1'b0);
            wr(12'h300, 32'h1 << ibit[i]);
            #1 chk({31'h0, irq}, 32'h1);
            rd(12'h380, 32'h1 << ibit[i]);
            #1 chk({31'h0, irq}, 32'h0);
            evp(ev_of(i), 16'h0, 2'b00, 1'b1);
            rd(12'h380, 32'h1 << ibit[i]);
            #1 chk({31'h0, irq}, 32'h0);
        end
        // flag raised in the very cycle of its clearing read survives
        @(posedge ref_clk);
        bus.addr <= 12'h380;
        bus.rd   <= 1'b1;
        ev       <= ev_of(4);
        @(posedge ref_clk);
        bus.rd   <= 1'b0;
        ev       <= '0;
        #1 chk(rdata, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(12'h380, 32'h1 << ibit[4]);
        // reset in mid-run returns every register to zero
        for (int k = 0; k < 5; k++) begin
            wr(ofs[k], 32'hFFFFFFFF);
        end
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            rd(ofs[k], 32'h0);
        end
        wrap_up();
    end

    initial begin
        #200000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule

`default_nettype wire
